// *** msr_seq.sv ***
// Step sequencer with restart, ground-fault check and home flag
//
// Function
// [R1] Release of lockout, reset or standby sets position to minus 45 degrees.
// [R2] Position zero means channel A full current, channel B zero.
// [R3] Direction low steps positive, direction high steps negative.
// [R4] Enable low turns outputs off; steps still advance position.
// [R5] Enable high resumes driving from the stored position.
// [R6] Reset low holds logic initialised and outputs off.
// [R7] Reset release restarts from the default position.
// [R8] Comparator ignored for about 0.75 us after each PWM on edge.
// [R9] Standby or lockout release holds outputs off for about 400 us.
// [R10] Charge pump stops in standby or lockout, resumes after release.
// [R11] With reset high, a 6 us ground-fault check follows off period.
// [R12] During the check all high-side switches are on.
// [R13] A detected ground fault turns outputs off and stops drive.
// [R14] Reset low at release skips the ground-fault check.
// [R15] Controller should release standby with enable low on slow pumps.
// [R16] Home indication only while test select is high.
// [R17] Mode selects choose 4, 8, 8, 16, 32 or 64 states.
// [R18] Direction change continues from the present state without jump.
// [R19] Home mode pulls the monitor pin low at mode-safe states.
// [R20] Position is a 64-state index stepped by 64 over resolution.
// [R21] Ground fault latches until standby, reset or lockout.
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "msr_map.svh"
module msr_seq #(
   parameter int OFF_CYC = `MSR_OFF_TIME_US * 1000 / `MSR_CLK_NS
) (
   input  wire logic        clk_sys_i,          // System clock, 125 MHz
   input  wire logic        rstn_i,             // Async reset, active low
   input  wire logic        step_pulse_a_i,     // Step clock, rising edge
   input  wire logic        step_pulse_b_i,     // Step clock, both edges
   input  wire logic        dir_i,              // Direction, high = minus
   input  wire logic        step_mode_sel0_i,   // Resolution select 0
   input  wire logic        step_mode_sel1_i,   // Resolution select 1
   input  wire logic        step_mode_sel2_i,   // Resolution select 2
   input  wire logic        enable_i,           // Output enable
   input  wire logic        motor_reset_n_i,    // Sequencer reset, low
   input  wire logic        sleep_request_n_i,  // Standby, active low
   input  wire logic        undervoltage_lockout_i, // Supply too low
   input  wire logic        pwm_on_i,           // PWM on phase
   input  wire logic        cmp_raw_i,          // Current comparator
   input  wire logic        gnd_fault_sense_i,  // Output short to ground
   input  wire logic        temp_monitor_home_flag_i, // Pin level
   output logic             temp_monitor_home_flag_o,  // Pin drive level
   output logic             temp_monitor_home_flag_oe_o, // Pull low
   output logic [5:0]       phase_index_o,      // Current-state position
   output logic             drive_en_o,         // Bridges may drive
   output logic             high_side_all_on_o, // Ground-fault check
   output logic             charge_pump_en_o,   // Charge pump running
   output logic             gnd_fault_o,        // Latched ground fault
   output logic             current_trip_o,     // Qualified current trip
   output logic             blank_o,            // Blanking active
   input  wire logic [3:0]  avs_address_i,      // Byte address
   input  wire logic        avs_read_i,         // Read request
   input  wire logic        avs_write_i,        // Write request
   input  wire logic [31:0] avs_writedata_i,    // Write data
   input  wire logic [3:0]  avs_byteenable_i,   // Byte lanes
   output logic [31:0]      avs_readdata_o,     // Read data
   output logic             avs_waitrequest_o   // Stall
);
   // ----------------------------------------------------------------
   // Timing counts
   // ----------------------------------------------------------------
   localparam int GF_CYC =
      (`MSR_GF_TIME_US * 1000 + `MSR_CLK_NS - 1) / `MSR_CLK_NS;
   localparam int BLANK_CYC =
      (`MSR_BLANK_TIME_NS + `MSR_CLK_NS - 1) / `MSR_CLK_NS;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Step size in 64ths of a turn for the selected resolution
   function automatic msr_pkg::msr_pos_t step_inc(
      input msr_pkg::msr_mode_t m);
      msr_pkg::msr_pos_t r;
      r = 6'h10;
      case (m)
         3'b000: r = 6'h10;
         3'b010: r = 6'h08;
         3'b001: r = 6'h08;
         3'b011: r = 6'h04;
         3'b100: r = 6'h02;
         3'b110: r = 6'h02;
         3'b101: r = 6'h01;
         3'b111: r = 6'h01;
         default: r = 6'h10;
      endcase
      return r;
   endfunction

   // Only full-step states are common to every resolution
   function automatic logic is_home(input msr_pkg::msr_pos_t p);
      return p[3:0] == `MSR_HOME_PHASE;
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   msr_pkg::msr_state_e state_r;
   msr_pkg::msr_state_e state_nxt;
   msr_pkg::msr_pos_t   pos_r;
   msr_pkg::msr_pos_t   pos_nxt;
   logic [16:0]         cnt_r;
   logic [16:0]         cnt_nxt;
   logic                step_a_prev_r;
   logic                step_b_prev_r;
   logic [1:0]          ctrl_r;
   logic                drive_r;
   logic                hs_r;
   logic                pump_r;
   logic                fault_r;
   logic                home_oe_r;
   logic                od_lvl_r;
   logic                wait_r;
   logic [31:0]         rdata_r;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire                 sleep_act;
   wire                 step_evt;
   wire                 off_done;
   wire                 gf_done;
   wire                 bus_req;
   wire                 bus_take;
   wire                 ctrl_wr;
   wire [31:0]          rd_mux;
   wire                 at_ctrl;
   wire                 at_status;
   msr_pkg::msr_mode_t  mode;
   msr_pkg::msr_pos_t   inc;

   assign mode      = {step_mode_sel2_i, step_mode_sel1_i,
                       step_mode_sel0_i};
   assign inc       = step_inc(mode); // [R17]
   assign sleep_act = ~sleep_request_n_i | undervoltage_lockout_i;
   assign step_evt  = (step_pulse_a_i & ~step_a_prev_r) |
                      (ctrl_r[`MSR_CTRL_STEPB_EN] &
                       (step_pulse_b_i ^ step_b_prev_r));
   assign off_done  = cnt_r == 17'(OFF_CYC - 1);
   assign gf_done   = cnt_r == 17'(GF_CYC - 1);

   // ----------------------------------------------------------------
   // Position
   // ----------------------------------------------------------------
   // Steps are counted in every state except while held initialised,
   // so a stop with enable low still tracks the controller.
   assign pos_nxt =
      (sleep_act || !motor_reset_n_i) ? `MSR_POS_DEFAULT : // [R1] [R6] [R7]
      !step_evt ? pos_r :                                  // [R5] [R18]
      dir_i ? pos_r - inc : pos_r + inc;                   // [R3] [R4] [R20]

   // ----------------------------------------------------------------
   // Restart sequence
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r + 17'h00001;
      case (state_r)
         msr_pkg::MSR_SLEEP: begin
            cnt_nxt = 17'h00000;
            if (!sleep_act) begin
               state_nxt = msr_pkg::MSR_REL_OFF;
            end
         end
         msr_pkg::MSR_REL_OFF: begin
            if (off_done) begin // [R9]
               cnt_nxt   = 17'h00000;
               state_nxt = motor_reset_n_i ? msr_pkg::MSR_GF_CHECK // [R11]
                                           : msr_pkg::MSR_RUN;     // [R14]
            end
         end
         msr_pkg::MSR_GF_CHECK: begin
            if (gnd_fault_sense_i) begin
               state_nxt = msr_pkg::MSR_GF_TRIP; // [R13]
            end else if (gf_done) begin
               state_nxt = msr_pkg::MSR_RUN;
            end
         end
         msr_pkg::MSR_RUN: begin
            cnt_nxt = 17'h00000;
         end
         msr_pkg::MSR_GF_TRIP: begin
            cnt_nxt = 17'h00000;
            if (!motor_reset_n_i) begin
               state_nxt = msr_pkg::MSR_RUN; // [R21]
            end
         end
         default: begin
            state_nxt = msr_pkg::MSR_SLEEP;
            cnt_nxt   = 17'h00000;
         end
      endcase
      if (sleep_act) begin
         state_nxt = msr_pkg::MSR_SLEEP; // [R21]
         cnt_nxt   = 17'h00000;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r       <= msr_pkg::MSR_SLEEP;
         cnt_r         <= 17'h00000;
         pos_r         <= `MSR_POS_DEFAULT;
         step_a_prev_r <= 1'b0;
         step_b_prev_r <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         cnt_r         <= cnt_nxt;
         pos_r         <= pos_nxt;
         step_a_prev_r <= step_pulse_a_i;
         step_b_prev_r <= step_pulse_b_i;
      end
   end

   // ----------------------------------------------------------------
   // Drive outputs
   // ----------------------------------------------------------------
   // Enable gates the bridges only; sequencing runs on regardless.
   wire drive_nxt = (state_nxt == msr_pkg::MSR_RUN) &&
                    enable_i && motor_reset_n_i;             // [R4] [R6] [R9]
   wire hs_nxt    = (state_nxt == msr_pkg::MSR_GF_CHECK);    // [R12]
   wire home_nxt  = ctrl_r[`MSR_CTRL_HOME_TEST] &&
                    is_home(pos_nxt);                        // [R16] [R19]

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         drive_r   <= 1'b0;
         hs_r      <= 1'b0;
         pump_r    <= 1'b0;
         fault_r   <= 1'b0;
         home_oe_r <= 1'b0;
         od_lvl_r  <= 1'b0;
      end else begin
         drive_r   <= drive_nxt;
         hs_r      <= hs_nxt;
         pump_r    <= ~sleep_act; // [R10]
         fault_r   <= state_nxt == msr_pkg::MSR_GF_TRIP; // [R13] [R21]
         home_oe_r <= home_nxt;
         od_lvl_r  <= 1'b0;
      end
   end

   assign phase_index_o               = pos_r; // [R2]
   assign drive_en_o                  = drive_r;
   assign high_side_all_on_o          = hs_r;
   assign charge_pump_en_o            = pump_r;
   assign gnd_fault_o                 = fault_r;
   assign temp_monitor_home_flag_o    = od_lvl_r;
   assign temp_monitor_home_flag_oe_o = home_oe_r;

   // ----------------------------------------------------------------
   // Current sense blanking
   // ----------------------------------------------------------------
   msr_blank #(
      .BLANK_CYC (BLANK_CYC)
   ) u_blank (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .pwm_on_i  (pwm_on_i),
      .cmp_raw_i (cmp_raw_i),
      .trip_o    (current_trip_o),
      .blank_o   (blank_o)
   );

   // ----------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------
   // One wait cycle per access: waitrequest idles high and drops for
   // exactly one cycle, which keeps read data a plain register.
   assign bus_req   = avs_read_i | avs_write_i;
   assign bus_take  = bus_req & ~wait_r;
   assign at_ctrl   = avs_address_i == `MSR_REG_CTRL;
   assign at_status = avs_address_i == `MSR_REG_STATUS;
   assign ctrl_wr   = bus_take & avs_write_i & at_ctrl &
                      avs_byteenable_i[0];
   assign rd_mux    =
      at_ctrl   ? {30'h0000_0000, ctrl_r} :
      at_status ? {13'h0000, mode,
                   drive_r, pump_r, temp_monitor_home_flag_i, fault_r,
                   1'b0, state_r, 2'h0, pos_r} :
      32'h0000_0000;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
         ctrl_r  <= `MSR_CTRL_RESET;
      end else begin
         wait_r  <= ~(bus_req & wait_r);
         rdata_r <= (avs_read_i & wait_r) ? rd_mux : 32'h0000_0000;
         if (ctrl_wr) begin
            ctrl_r <= avs_writedata_i[1:0];
         end
      end
   end

   assign avs_readdata_o    = rdata_r;
   assign avs_waitrequest_o = wait_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   release_default_a: assert property ( // [R1]
      $fell(sleep_act) && motor_reset_n_i && !step_evt
      |=> pos_r == `MSR_POS_DEFAULT)
      else $error("position not default after release");
   step_dir_a: assert property ( // [R3]
      step_evt && !sleep_act && motor_reset_n_i
      |=> pos_r == ($past(dir_i) ? $past(pos_r) - $past(inc)
                                 : $past(pos_r) + $past(inc)))
      else $error("step moved position wrongly");
   hold_pos_a: assert property ( // [R5]
      !step_evt && !sleep_act && motor_reset_n_i |=> $stable(pos_r))
      else $error("position moved without step");
   enable_off_a: assert property ( // [R4]
      !enable_i |=> !drive_en_o)
      else $error("drive on while enable low");
   reset_off_a: assert property ( // [R6]
      !motor_reset_n_i |=> !drive_en_o && pos_r == `MSR_POS_DEFAULT)
      else $error("reset did not hold sequencer");
   off_period_a: assert property ( // [R9]
      state_r == msr_pkg::MSR_REL_OFF |-> !drive_en_o && !hs_r)
      else $error("outputs on in release off period");
   pump_stop_a: assert property ( // [R10]
      sleep_act |=> !charge_pump_en_o)
      else $error("charge pump on in standby");
   gf_enter_a: assert property ( // [R11]
      state_r == msr_pkg::MSR_REL_OFF && off_done && motor_reset_n_i
      && !sleep_act |=> state_r == msr_pkg::MSR_GF_CHECK && hs_r)
      else $error("ground-fault check not entered");
   gf_skip_a: assert property ( // [R14]
      state_r == msr_pkg::MSR_REL_OFF && off_done && !motor_reset_n_i
      && !sleep_act |=> state_r == msr_pkg::MSR_RUN)
      else $error("ground-fault check not skipped");
   gf_trip_a: assert property ( // [R13]
      state_r == msr_pkg::MSR_GF_CHECK && gnd_fault_sense_i && !sleep_act
      |=> gnd_fault_o && !drive_en_o)
      else $error("ground fault not latched");
   home_gate_a: assert property ( // [R16]
      temp_monitor_home_flag_oe_o |-> $past(ctrl_r[`MSR_CTRL_HOME_TEST]))
      else $error("home flag without test select");
   bus_answer_a: assert property (
      bus_req && wait_r |=> !avs_waitrequest_o)
      else $error("bus not answered in one cycle");
endmodule

// *** msr_map.svh ***
// Offsets, field positions, reset values and timing figures of the sequencer
`ifndef MSR_MAP_SVH
`define MSR_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MSR_REG_CTRL        4'h0
`define MSR_REG_STATUS      4'h4

// ----------------------------------------------------------------
// Control fields and reset value
// ----------------------------------------------------------------
`define MSR_CTRL_HOME_TEST  0
`define MSR_CTRL_STEPB_EN   1
`define MSR_CTRL_RESET      2'h0

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define MSR_ST_POS_LSB      0
`define MSR_ST_STATE_LSB    8
`define MSR_ST_GF_FAULT     12
`define MSR_ST_HOME_PIN     13
`define MSR_ST_PUMP_ON      14
`define MSR_ST_DRIVE_ON     15
`define MSR_ST_MODE_LSB     16

// ----------------------------------------------------------------
// Position: 64 states per electrical turn, 0 = A full, B zero
// ----------------------------------------------------------------
`define MSR_POS_DEFAULT     6'h38
`define MSR_HOME_PHASE      4'h8

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define MSR_CLK_NS          8
`define MSR_OFF_TIME_US     400
`define MSR_GF_TIME_US      6
`define MSR_BLANK_TIME_NS   750

`endif

// *** msr_pkg.sv ***
// Types shared by the step sequencer files
package msr_pkg;
   typedef logic [5:0] msr_pos_t;
   typedef logic [2:0] msr_mode_t;
   typedef enum logic [2:0] {
      MSR_SLEEP,
      MSR_REL_OFF,
      MSR_GF_CHECK,
      MSR_RUN,
      MSR_GF_TRIP
   } msr_state_e;
endpackage

// *** msr_blank.sv ***
// Current comparator blanking after each PWM on transition
`timescale 1ns/1ps
`include "msr_map.svh"
module msr_blank #(
   parameter int BLANK_CYC = 94
) (
   input  wire logic clk_sys_i,  // System clock
   input  wire logic rstn_i,     // Async reset, active low
   input  wire logic pwm_on_i,   // PWM on phase
   input  wire logic cmp_raw_i,  // Raw current comparator
   output logic      trip_o,     // Qualified current trip
   output logic      blank_o     // Blanking window active
);
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic       pwm_prev_r;
   logic       trip_r;
   logic       blank_r;
   wire        on_rise;

   assign on_rise = pwm_on_i & ~pwm_prev_r;
   assign cnt_nxt = on_rise ? 7'(BLANK_CYC) :
                    (cnt_r != 7'h00) ? cnt_r - 7'h01 : 7'h00;
   assign trip_o  = trip_r;
   assign blank_o = blank_r;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r      <= 7'h00;
         pwm_prev_r <= 1'b0;
         trip_r     <= 1'b0;
         blank_r    <= 1'b0;
      end else begin
         cnt_r      <= cnt_nxt;
         pwm_prev_r <= pwm_on_i;
         // Noise right after switching must not end the on phase
         trip_r     <= pwm_on_i & cmp_raw_i & (cnt_nxt == 7'h00); // [R8]
         blank_r    <= cnt_nxt != 7'h00;
      end
   end

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   blank_start_a: assert property ( // [R8]
      on_rise |=> !trip_r [*8])
      else $error("trip seen at start of blanking");
   blank_hold_a: assert property ( // [R8]
      cnt_r != 7'h00 |-> !trip_r && blank_r)
      else $error("trip seen inside blanking window");
endmodule

// *** msr_step_ctl.sv ***
// Step and direction pulse controller model facing the sequencer
`timescale 1ns/1ps
module msr_step_ctl (
   input  wire logic       clk_sys_i, // System clock
   input  wire logic       go_i,      // Issue one step
   input  wire logic       use_b_i,   // Step on the both-edge input
   input  wire logic       dir_i,     // Requested direction
   input  wire logic [2:0] mode_i,    // Requested resolution
   output logic            step_a_o,  // Rising-edge step clock
   output logic            step_b_o,  // Both-edge step clock
   output logic            dir_o,     // Direction pin
   output logic [2:0]      mode_o,    // Resolution pins
   output logic            busy_o     // Step in progress
);
   initial begin
      {step_a_o, step_b_o, dir_o, mode_o, busy_o} = '0;
      forever begin
         @(posedge clk_sys_i);
         if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            dir_o  <= dir_i;
            mode_o <= mode_i;
            // Direction and mode settle before the edge and hold after it
            repeat (3) @(posedge clk_sys_i);
            if (use_b_i)
               step_b_o <= ~step_b_o;
            else
               step_a_o <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
            step_a_o <= 1'b0;
            repeat (3) @(posedge clk_sys_i);
            busy_o <= 1'b0;
         end
      end
   end
endmodule

// *** test_msr_seq.sv ***
// Self-checking bench for the step sequencer
`timescale 1ns/1ps
module test_msr_seq;
   localparam int OFF = 20;
   localparam logic [5:0] INC [8] = '{16, 8, 8, 4, 2, 1, 2, 1};
   logic        clk_sys_i, rstn_i, en, mrst_n, sleep_n, lockout, pwm, cmp, gf;
   logic        go, use_b, gdir, sa, sb, dir, busy, rd, wr, wreq;
   logic        oe, hlvl, drv, hs, cp, gfo, trip, blank;
   logic [2:0]  gmode, mode;
   logic [3:0]  adr, be;
   logic [31:0] wd, rdat, rv;
   logic [5:0]  pidx, exp_pos, last;
   logic [5:0]  q[$];
   int          err_total, n_checks;
   wire         hpin = oe ? hlvl : 1'b1; // Pull-up on the open-drain pin

   msr_step_ctl ctl (.clk_sys_i(clk_sys_i), .go_i(go), .use_b_i(use_b),
      .dir_i(gdir), .mode_i(gmode), .step_a_o(sa), .step_b_o(sb),
      .dir_o(dir), .mode_o(mode), .busy_o(busy));
   msr_seq #(.OFF_CYC(OFF)) uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .step_pulse_a_i(sa), .step_pulse_b_i(sb), .dir_i(dir),
      .step_mode_sel0_i(mode[0]), .step_mode_sel1_i(mode[1]),
      .step_mode_sel2_i(mode[2]), .enable_i(en), .motor_reset_n_i(mrst_n),
      .sleep_request_n_i(sleep_n), .undervoltage_lockout_i(lockout),
      .pwm_on_i(pwm), .cmp_raw_i(cmp), .gnd_fault_sense_i(gf),
      .temp_monitor_home_flag_i(hpin), .temp_monitor_home_flag_o(hlvl),
      .temp_monitor_home_flag_oe_o(oe), .phase_index_o(pidx),
      .drive_en_o(drv), .high_side_all_on_o(hs), .charge_pump_en_o(cp),
      .gnd_fault_o(gfo), .current_trip_o(trip), .blank_o(blank),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq));

   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   // Note a position change for the watching process
   task automatic setp(input logic [5:0] p);
      if (p !== exp_pos)
         q.push_back(p);
      exp_pos = p;
   endtask

   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int t;
      t = 0;
      adr <= a;
      wd  <= d;
      wr  <= w;
      rd  <= !w;
      be  <= 4'hf;
      do begin
         @(posedge clk_sys_i);
         t++;
      end while (wreq !== 1'b0 && t < 50);
      r = rdat;
      chk(wreq, 0);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic step(input logic b, input logic d, input logic [2:0] m,
                       input logic live);
      int t;
      t = 0;
      use_b <= b;
      gdir  <= d;
      gmode <= m;
      go    <= 1'b1;
      @(posedge clk_sys_i);
      go <= 1'b0;
      if (live)
         setp(d ? exp_pos - INC[m] : exp_pos + INC[m]);
      do begin
         @(posedge clk_sys_i);
         t++;
      end while (busy !== 1'b0 && t < 20);
      chk(busy, 0);
   endtask

   // Release sequence: outputs off, then optional high-side check window
   task automatic rel(input int hexp, input int dwin);
      int h;
      h = 0;
      for (int i = 0; i < OFF + 780; i++) begin
         @(posedge clk_sys_i);
         h += int'(hs === 1'b1);
         if (i < dwin)
            chk(drv, 0);
      end
      if (hexp >= 0)
         chk(h, hexp);
   endtask

   always @(posedge clk_sys_i) begin
      if (pidx !== last) begin
         if (q.size() == 0)
            chk(pidx, last);
         else
            chk(pidx, q.pop_front());
      end
      last = pidx;
   end

   initial begin
      {rstn_i, pwm, cmp, gf, go, use_b, gdir, rd, wr, lockout} = '0;
      {en, mrst_n, sleep_n} = 3'b111;
      {adr, be, gmode, wd} = '0;
      exp_pos = 'x;
      last = 'x;
      void'($urandom(32'h437e));
      setp(6'h38);
      cyc(8);
      rstn_i <= 1'b1;
      rel(750, OFF + 750);
      chk(drv, 1);
      chk(cp, 1);
      bus(0, 4'h4, 0, rv);
      chk(rv[10:8], 3'h3);
      $display("reset release done");
      bus(1, 4'h0, 32'h0000_0002, rv);
      for (int m = 0; m < 8; m++)
         repeat (2) step(1'($urandom), 1'($urandom), 3'(m), 1);
      bus(0, 4'h4, 0, rv);
      chk(rv[5:0], exp_pos);
      chk(rv[18:16], 3'h7);
      bus(0, 4'h0, 0, rv);
      chk(rv, 32'h0000_0002);
      bus(0, 4'h8, 0, rv);
      chk(rv, 0);
      $display("modes done");
      en <= 1'b0;
      cyc(3);
      chk(drv, 0);
      step(0, 1, 3'h1, 1);
      step(0, 1, 3'h1, 1);
      en <= 1'b1;
      cyc(3);
      chk(drv, 1);
      $display("enable done");
      // Home test on for the first half, off for the second
      for (int i = 0; i < 32; i++) begin
         if (i == 0 || i == 16)
            bus(1, 4'h0, (i == 0) ? 32'h0000_0001 : 32'h0000_0000, rv);
         step(0, 0, 3'h7, 1);
         chk(oe, i < 16 && exp_pos[3:0] == 4'h8);
         chk(hlvl, 0);
      end
      $display("home done");
      mrst_n <= 1'b0;
      setp(6'h38);
      cyc(3);
      chk(drv, 0);
      step(0, 0, 3'h3, 0);
      mrst_n <= 1'b1;
      cyc(3);
      step(0, 0, 3'h3, 1);
      $display("motor reset done");
      sleep_n <= 1'b0;
      setp(6'h38);
      cyc(3);
      chk(cp, 0);
      // Slow pump: leave standby with outputs disabled
      en <= 1'b0;
      gf <= 1'b1;
      sleep_n <= 1'b1;
      rel(1, OFF + 780);
      chk(gfo, 1);
      en <= 1'b1;
      cyc(4);
      chk(drv, 0);
      gf <= 1'b0;
      sleep_n <= 1'b0;
      cyc(3);
      chk(gfo, 0);
      mrst_n <= 1'b0;
      sleep_n <= 1'b1;
      rel(0, OFF);
      mrst_n <= 1'b1;
      cyc(3);
      step(0, 1, 3'h0, 1);
      lockout <= 1'b1;
      setp(6'h38);
      cyc(3);
      chk(cp, 0);
      lockout <= 1'b0;
      rel(750, OFF + 750);
      chk(drv, 1);
      $display("standby and lockout done");
      cmp <= 1'b1;
      cyc(3);
      pwm <= 1'b1;
      // 94 blanked cycles, then the comparator passes
      for (int i = 0; i < 100; i++) begin
         @(posedge clk_sys_i);
         chk(trip, i > 94);
      end
      chk(trip, 1);
      chk(blank, 0);
      $display("blanking done");
      results();
   end

   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_total++;
      results();
   end
endmodule
